// ==== core/qseq_pkg.sv ====
// constants for the four-phase fetch/execute sequencer
package qseq_pkg;
    localparam int unsigned PC_W        = 13;       // program counter width
    localparam int unsigned IW_W        = 14;       // instruction word width
    localparam int unsigned DA_W        = 9;        // data memory address width
    localparam int unsigned DD_W        = 8;        // data memory word width
    localparam int unsigned NUM_PHASES  = 4;        // phases per instr cycle
    localparam logic [12:0] PC_RESET    = 13'h0000; // first fetch address
    localparam logic [3:0]  PH_ONE      = 4'h1;     // one-hot phase codes
    localparam logic [3:0]  PH_TWO      = 4'h2;
    localparam logic [3:0]  PH_THREE    = 4'h4;
    localparam logic [3:0]  PH_FOUR     = 4'h8;
    localparam logic [13:0] IW_NOP      = 14'h0000; // bubble word
endpackage

// ==== core/phase_if.sv ====
// phase strobes shared between the phase generator and the sequencer
`timescale 1ns/1ps
interface phase_if;
    logic [3:0] ph;   // one-hot: bit0 phase_one .. bit3 phase_four
    modport gen (output ph);
    modport use_ph (input ph);
endinterface

// ==== core/phase_gen.sv ====
// divide-by-four one-hot phase generator
`timescale 1ns/1ps
module phase_gen
    import qseq_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // phase strobes
    phase_if.gen      phs
);
    typedef enum logic [3:0] {
        S_ONE   = 4'b0001,
        S_TWO   = 4'b0010,
        S_THREE = 4'b0100,
        S_FOUR  = 4'b1000
    } phase_t;

    phase_t ph_ff;
    phase_t nxt_ph;

    // ----------------------------------------------------------------
    // phase rotation
    // ----------------------------------------------------------------
    // one-hot so phases can never overlap
    always_comb begin
        unique case (ph_ff)
            S_ONE:   nxt_ph = S_TWO;
            S_TWO:   nxt_ph = S_THREE;
            S_THREE: nxt_ph = S_FOUR;
            S_FOUR:  nxt_ph = S_ONE;
            default: nxt_ph = S_ONE;
        endcase
    end

    // restart at phase one
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ph_ff <= S_ONE;
        end else begin
            ph_ff <= nxt_ph;
        end
    end

    assign phs.ph = ph_ff;

    property p_onehot;
        @(posedge i_clk) disable iff (i_sys_rst) $onehot(ph_ff);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("phase not one-hot");

    // entered from phase four: phase one is held through reset and
    // again at the release edge, so starting there would misfire
    property p_period;
        @(posedge i_clk) disable iff (i_sys_rst)
            (ph_ff == S_FOUR) |=> (ph_ff == S_ONE) ##4 (ph_ff == S_ONE);
    endproperty
    a_period: assert property (p_period)
        else $error("phase period not 4");
endmodule

// ==== core/quad_phase_seq.sv ====
// four-phase two-stage fetch/execute pipeline sequencer
// ------------------------------------------------------------------
// Overview of operation
// - oscillator divided by four into four non-overlapping ordered phases
// - one instruction cycle is exactly phases one through four
// - program counter increments in phase one of every cycle except the first after reset or a jump
// - fetched program word is latched at phase four
// - fetch of next word overlaps execution of current word
// - instruction register loads at phase one, executes in two to four
// - data operand read in phase two, destination write in phase four
// - program counter changes cost two cycles; prefetched word is flushed
// - thirteen-bit program counter, addresses wrap around
// - after reset fetching starts at address zero
// ------------------------------------------------------------------
`timescale 1ns/1ps
module quad_phase_seq
    import qseq_pkg::*;
(
    // clock and reset (i_clk is the oscillator_input_pin)
    input  wire logic            i_clk,
    input  wire logic            i_sys_rst,
    // program memory
    output logic [PC_W-1:0]      o_prog_addr,
    input  wire logic [IW_W-1:0] i_prog_data,
    // branch request from decode, valid during the executing cycle
    input  wire logic            i_jump_req,
    input  wire logic [PC_W-1:0] i_jump_target,
    // data memory control from decode
    input  wire logic [DA_W-1:0] i_dm_addr,
    input  wire logic            i_dm_wr_req,
    input  wire logic [DD_W-1:0] i_dm_wdata,
    // data memory strobes
    output logic                 o_dm_rd,
    output logic                 o_dm_wr,
    output logic [DA_W-1:0]      o_dm_addr,
    output logic [DD_W-1:0]      o_dm_wdata,
    // pipeline state
    output logic [3:0]           o_phase,
    output logic [IW_W-1:0]      o_instr,
    output logic                 o_instr_valid
);
    phase_if phs ();

    phase_gen u_phase_gen (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .phs       (phs)
    );

    logic [PC_W-1:0] pc_ff,     nxt_pc;
    logic [IW_W-1:0] fetch_ff,  nxt_fetch;
    logic            fvld_ff,   nxt_fvld;
    logic [IW_W-1:0] ir_ff,     nxt_ir;
    logic            ivld_ff,   nxt_ivld;
    logic            flush_ff,  nxt_flush;
    logic            rd_ff,     nxt_rd;
    logic            wr_ff,     nxt_wr;
    logic [DA_W-1:0] da_ff,     nxt_da;
    logic [DD_W-1:0] wd_ff,     nxt_wd;
    logic [3:0]      ph_out_ff, nxt_ph_out;

    // decoded phase strobes; each is high for one clock per cycle
    logic ph1, ph2, ph4;
    assign ph1 = phs.ph[0];
    assign ph2 = phs.ph[1];
    assign ph4 = phs.ph[3];

    // ----------------------------------------------------------------
    // fetch stage and program counter
    // ----------------------------------------------------------------
    // pc points at the word being fetched; a jump taken in the
    // executing cycle is loaded at its phase four so the next
    // phase one fetches the target; the word fetched in parallel
    // is already wrong, so it is marked for flushing
    always_comb begin
        nxt_pc    = pc_ff;
        nxt_fetch = fetch_ff;
        nxt_fvld  = fvld_ff;
        nxt_flush = flush_ff;
        if (ph1) begin
            nxt_flush = 1'b0;
            if (!flush_ff) begin
                nxt_pc = pc_ff + 13'h0001;
            end
        end
        if (ph4) begin
            nxt_fetch = i_prog_data;
            nxt_fvld  = 1'b1;
            if (i_jump_req && ivld_ff) begin
                nxt_pc    = i_jump_target;
                nxt_fvld  = 1'b0;
                nxt_flush = 1'b1;
            end
        end
    end

    // the address bus shows pc while counting; wrap comes from width
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pc_ff    <= PC_RESET;
            fetch_ff <= IW_NOP;
            fvld_ff  <= 1'b0;
            flush_ff <= 1'b1;     // first phase one fetches address zero
        end else begin
            pc_ff    <= nxt_pc;
            fetch_ff <= nxt_fetch;
            fvld_ff  <= nxt_fvld;
            flush_ff <= nxt_flush;
        end
    end

    // ----------------------------------------------------------------
    // execute stage
    // ----------------------------------------------------------------
    // ir takes the prefetched word at phase one while the next fetch
    // runs in parallel; an invalid slot executes as a bubble
    always_comb begin
        nxt_ir   = ir_ff;
        nxt_ivld = ivld_ff;
        nxt_rd   = 1'b0;
        nxt_wr   = 1'b0;
        nxt_da   = da_ff;
        nxt_wd   = wd_ff;
        // load the coming phase so the visible phase is the live one
        nxt_ph_out = {phs.ph[2:0], phs.ph[3]};
        if (ph1) begin
            nxt_ir   = fvld_ff ? fetch_ff : IW_NOP;
            nxt_ivld = fvld_ff;
        end
        // strobes are registered so they land in phase two and four
        if (phs.ph[0] && fvld_ff) begin
            nxt_rd = 1'b1;
            nxt_da = i_dm_addr;
        end
        if (phs.ph[2] && ivld_ff && i_dm_wr_req) begin
            nxt_wr = 1'b1;
            nxt_da = i_dm_addr;
            nxt_wd = i_dm_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ir_ff     <= IW_NOP;
            ivld_ff   <= 1'b0;
            rd_ff     <= 1'b0;
            wr_ff     <= 1'b0;
            da_ff     <= '0;
            wd_ff     <= '0;
            ph_out_ff <= PH_ONE;
        end else begin
            ir_ff     <= nxt_ir;
            ivld_ff   <= nxt_ivld;
            rd_ff     <= nxt_rd;
            wr_ff     <= nxt_wr;
            da_ff     <= nxt_da;
            wd_ff     <= nxt_wd;
            ph_out_ff <= nxt_ph_out;
        end
    end

    // outputs straight from flops; o_phase tracks the live internal
    // phase, so the registered strobes stand in the phase it shows
    assign o_prog_addr   = pc_ff;
    assign o_instr       = ir_ff;
    assign o_instr_valid = ivld_ff;
    assign o_dm_rd       = rd_ff;
    assign o_dm_wr       = wr_ff;
    assign o_dm_addr     = da_ff;
    assign o_dm_wdata    = wd_ff;
    assign o_phase       = ph_out_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_pc_inc;
        @(posedge i_clk) disable iff (i_sys_rst)
            (ph1 && !flush_ff) |=> (pc_ff == $past(pc_ff) + 13'h0001);
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("pc did not step");

    property p_pc_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
            (!ph1 && !ph4) |=> $stable(pc_ff);
    endproperty
    a_pc_hold: assert property (p_pc_hold)
        else $error("pc moved off phase");

    property p_latch;
        @(posedge i_clk) disable iff (i_sys_rst)
            ph4 |=> (fetch_ff == $past(i_prog_data));
    endproperty
    a_latch: assert property (p_latch) else $error("fetch not latched");

    property p_ir_load;
        @(posedge i_clk) disable iff (i_sys_rst)
            (ph1 && fvld_ff) |=> (ir_ff == $past(fetch_ff)) && ivld_ff;
    endproperty
    a_ir_load: assert property (p_ir_load) else $error("ir not loaded");

    property p_rd_phase;
        @(posedge i_clk) disable iff (i_sys_rst)
            o_dm_rd |-> (o_phase == PH_TWO);
    endproperty
    a_rd_phase: assert property (p_rd_phase)
        else $error("read off phase");

    property p_wr_phase;
        @(posedge i_clk) disable iff (i_sys_rst)
            o_dm_wr |-> (o_phase == PH_FOUR);
    endproperty
    a_wr_phase: assert property (p_wr_phase)
        else $error("write off phase");

    sequence s_jump;
        ph4 && i_jump_req && ivld_ff;
    endsequence

    // the phase one right after the jump finds no prefetch, executes
    // a bubble, and the target word runs one cycle later
    sequence s_bubble;
        (ph1 && !fvld_ff) ##1 !ivld_ff ##4 ivld_ff;
    endsequence

    property p_flush;
        @(posedge i_clk) disable iff (i_sys_rst)
            s_jump |-> ##1 (pc_ff == $past(i_jump_target)) ##0 s_bubble;
    endproperty
    a_flush: assert property (p_flush)
        else $error("branch not flushed");

    property p_pipe;
        @(posedge i_clk) disable iff (i_sys_rst)
            (ph4 && ivld_ff && !i_jump_req) |=> ##1 ivld_ff;
    endproperty
    a_pipe: assert property (p_pipe) else $error("pipeline stalled");
endmodule

// ==== tb/seq_mem_model.sv ====
// program and data memory model facing the sequencer
`timescale 1ns/1ps
module seq_mem_model
    import qseq_pkg::*;
(
    // clock
    input  wire logic            i_clk,
    // program memory side
    input  wire logic [PC_W-1:0] i_prog_addr,
    output logic [IW_W-1:0]      o_prog_data,
    // data memory side
    input  wire logic            i_dm_wr,
    input  wire logic [DA_W-1:0] i_dm_addr,
    input  wire logic [DD_W-1:0] i_dm_wdata
);
    logic [DD_W-1:0] dmem [0:511];

    // only 4k words exist, so upper addresses alias the lower half
    assign o_prog_data = {2'b10, i_prog_addr[11:0]};
    // destination write lands on the edge that ends the strobe
    always @(posedge i_clk) begin
        if (i_dm_wr) begin
            dmem[i_dm_addr] <= i_dm_wdata;
        end
    end
endmodule

// ==== tb/tb_quad_phase_seq.sv ====
// self-checking bench for the four-phase fetch/execute sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; \
    if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_quad_phase_seq;
    import qseq_pkg::*;
    logic            i_clk = 1'b0;
    logic            i_sys_rst = 1'b1;
    logic [IW_W-1:0] prog_data;
    logic            i_jump_req = 1'b0;
    logic [PC_W-1:0] i_jump_target = '0;
    logic [DA_W-1:0] i_dm_addr = 9'h0a5;
    logic            i_dm_wr_req = 1'b0;
    logic [DD_W-1:0] i_dm_wdata = 8'h00;
    logic            o_dm_rd, o_dm_wr, o_instr_valid;
    logic [PC_W-1:0] o_prog_addr;
    logic [DA_W-1:0] o_dm_addr;
    logic [DD_W-1:0] o_dm_wdata;
    logic [3:0]      o_phase, prev_ph;
    logic [IW_W-1:0] o_instr;
    int              fail_count = 0;
    int              checks_done = 0;
    int              settle = 0;
    int              gap;

    always #5 i_clk = ~i_clk;

    quad_phase_seq dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .o_prog_addr(o_prog_addr), .i_prog_data(prog_data),
        .i_jump_req(i_jump_req), .i_jump_target(i_jump_target),
        .i_dm_addr(i_dm_addr), .i_dm_wr_req(i_dm_wr_req),
        .i_dm_wdata(i_dm_wdata), .o_dm_rd(o_dm_rd), .o_dm_wr(o_dm_wr),
        .o_dm_addr(o_dm_addr), .o_dm_wdata(o_dm_wdata),
        .o_phase(o_phase), .o_instr(o_instr),
        .o_instr_valid(o_instr_valid));
    seq_mem_model mem_u (.i_clk(i_clk), .i_prog_addr(o_prog_addr),
        .o_prog_data(prog_data), .i_dm_wr(o_dm_wr),
        .i_dm_addr(o_dm_addr), .i_dm_wdata(o_dm_wdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [IW_W-1:0] exp_word(logic [PC_W-1:0] a);
        return {2'b10, a[11:0]};
    endfunction

    // phase order and strobe placement; rotation is judged only once
    // two samples have passed since release, so prev_ph is real
    always @(negedge i_clk) begin
        if (i_sys_rst) begin
            settle = 0;
        end else begin
            if (settle > 1)
                `CHK("phase", {prev_ph[2:0], prev_ph[3]}, o_phase)
            if (o_dm_rd === 1'b1) `CHK("rd phase", PH_TWO, o_phase)
            if (o_dm_wr === 1'b1) `CHK("wr phase", PH_FOUR, o_phase)
            prev_ph = o_phase;
            settle++;
        end
    end

    task automatic finish_test();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // bounded wait for the next operand read strobe, counting clocks
    task automatic wait_rd(output int n);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_dm_rd !== 1'b1 && n < 20);
    endtask

    task automatic check_exec(input logic [PC_W-1:0] a);
        `CHK("instr", exp_word(a), o_instr)
        `CHK("valid", 1'b1, o_instr_valid)
        `CHK("pc", PC_W'(a + 1'b1), o_prog_addr)
        `CHK("rd addr", i_dm_addr, o_dm_addr)
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_run();
        @(posedge i_clk) i_sys_rst <= 1'b1;
        repeat (8) @(posedge i_clk);
        @(negedge i_clk);
        `CHK("rst phase", PH_ONE, o_phase)
        `CHK("rst pc", PC_RESET, o_prog_addr)
        `CHK("rst valid", 1'b0, o_instr_valid)
        `CHK("rst instr", IW_NOP, o_instr)
        @(posedge i_clk) i_sys_rst <= 1'b0;
        wait_rd(gap);
        check_exec(13'h0000);
        for (int k = 1; k < 6; k++) begin
            wait_rd(gap);
            `CHK("cycle len", 4, gap)
            check_exec(PC_W'(k));
        end
    endtask

    task automatic t_store();
        int n;
        wait_rd(gap);
        @(posedge i_clk);
        i_dm_wr_req <= 1'b1;
        i_dm_addr <= 9'h1ff;
        i_dm_wdata <= 8'h5a;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_dm_wr !== 1'b1 && n < 8);
        `CHK("wr delay", 2, n)
        `CHK("wr addr", 9'h1ff, o_dm_addr)
        `CHK("wr data", 8'h5a, o_dm_wdata)
        @(posedge i_clk) i_dm_wr_req <= 1'b0;
        @(negedge i_clk);
        `CHK("stored", 8'h5a, mem_u.dmem[9'h1ff])
    endtask

    // jump held through the bubble, which must ignore it
    task automatic t_jump(input logic [PC_W-1:0] t);
        wait_rd(gap);
        @(posedge i_clk);
        i_jump_req <= 1'b1;
        i_jump_target <= t;
        wait_rd(gap);
        `CHK("jump len", 8, gap)
        check_exec(t);
        @(posedge i_clk) i_jump_req <= 1'b0;
        wait_rd(gap);
        `CHK("after jump", 4, gap)
        check_exec(PC_W'(t + 1'b1));
    endtask

    initial begin
        #20us;
        fail_count++;
        finish_test();
    end

    initial begin
        t_reset_run();
        t_store();
        t_jump(13'h1fff);
        t_jump(13'h0800);
        t_reset_run();
        finish_test();
    end
endmodule
